// *** pfc_pkg.sv ***
// Constants for the PFC start-up and line configuration block.
// Assumes a 10 MHz system clock and byte-wide register port.
package pfc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] PFC_ADDR_LINE_PERIOD_LOWER = 16'hfe27;
  localparam logic [15:0] PFC_ADDR_LINE_PERIOD_UPPER = 16'hfe28;
  localparam logic [15:0] PFC_ADDR_LOW_LINE_GAIN     = 16'hfe29;
  localparam logic [15:0] PFC_ADDR_LOW_LINE_ZERO     = 16'hfe2a;
  localparam logic [15:0] PFC_ADDR_HIGH_LINE_GAIN    = 16'hfe2b;
  localparam logic [15:0] PFC_ADDR_HIGH_LINE_ZERO    = 16'hfe2c;
  localparam logic [15:0] PFC_ADDR_RAMP_TIMING       = 16'hfe2d;
  localparam logic [15:0] PFC_ADDR_SURGE_TIMING      = 16'hfe2e;
  // ----------------------------------------
  // Field masks and reset values
  // ----------------------------------------
  localparam logic [7:0] PFC_RAMP_MASK   = 8'h3f;
  localparam logic [7:0] PFC_SURGE_MASK  = 8'h1f;
  localparam logic [7:0] PFC_RESET_VALUE = 8'h00;
  localparam int         PFC_SS_DELAY_LSB = 3;
  localparam int         PFC_VLOW_SEL_LSB = 3;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam real        PFC_CLK_MHZ      = 10.0;
  localparam real        PFC_PERIOD_LSB_US = 163.84;
  localparam int         PFC_MS_US        = 1000;
  localparam int         PFC_MS_CYCLES    = int'(PFC_MS_US * PFC_CLK_MHZ);
  localparam logic [9:0] PFC_VLOW_2MS     = 10'h002;
  localparam logic [9:0] PFC_VLOW_4MS     = 10'h004;
  // Soft-start ramp lengths in ms, per code
  localparam logic [9:0] PFC_RAMP_MS [8] = '{10'h070, 10'h0a8, 10'h0e0, 10'h118,
                                              10'h188, 10'h1f8, 10'h268, 10'h2d8};
  // ----------------------------------------
  // Start-up states
  // ----------------------------------------
  typedef enum logic [2:0] {
    PFC_ST_OFF        = 3'b000,
    PFC_ST_SURGE_WAIT = 3'b001,
    PFC_ST_RAMP_WAIT  = 3'b010,
    PFC_ST_RAMP       = 3'b011,
    PFC_ST_RUN        = 3'b100
  } pfc_state_t;
endpackage

// *** pfc_dly_if.sv ***
// Carrier between start-up sequencer and line-cycle delay counter.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
interface pfc_dly_if;
  logic       start;
  logic [2:0] cycles;
  logic       tick;
  logic       done;
  modport owner (output start, output cycles, output tick, input done);
  modport timer (input start, input cycles, input tick, output done);
endinterface

// *** pfc_cycle_delay.sv ***
// Counts a given number of full ac line cycles after a start pulse.
// Assumes tick is a one-cycle pulse per full line cycle.
`timescale 1ns/1ns
module pfc_cycle_delay (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Sequencer side
  pfc_dly_if.timer  dly
);
  logic [2:0] left_q;
  logic       busy_q;

  // Load on start, count down on each line cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      left_q <= 3'h0;
      busy_q <= 1'b0;
    end else if (dly.start) begin
      left_q <= dly.cycles;
      busy_q <= 1'b1;
    end else if (busy_q && left_q == 3'h0) begin
      busy_q <= 1'b0;
    end else if (busy_q && dly.tick) begin
      left_q <= left_q - 3'h1;
    end
  end

  // Done when the count has run out
  assign dly.done = busy_q && (left_q == 3'h0);
endmodule // pfc_cycle_delay

// *** pfc_startup_line_config.sv ***
// Start-up sequencing and line configuration registers of a PFC controller.
// Assumes line ticks and measurements are synchronous to clk_sys.
// Function
// - Hold an 8-bit upper line period limit in 163.84 us steps.
// - Hold an 8-bit lower line period limit in the same steps, bounding the valid window.
// - On low line use a dedicated 8-bit current-loop gain and zero.
// - On high line use a separate 8-bit current-loop gain and zero.
// - Pick the high-line pair when input voltage is above the high-line threshold.
// - Wait 0 to 7 full line cycles after inrush asserts before soft start.
// - Run soft start for 112, 168, 224, 280, 392, 504, 616 or 728 ms per code.
// - Time the input-low flag over a quarter cycle, half cycle, 2 ms or 4 ms.
// - Assert inrush 0 to 7 full line cycles after undervoltage clears.
`timescale 1ns/1ns
module pfc_startup_line_config #(
  parameter int MS_CYCLES = pfc_pkg::PFC_MS_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Line measurements
  input  wire logic        line_cycle_tick,
  input  wire logic        line_quarter_tick,
  input  wire logic [7:0]  line_period_meas,
  input  wire logic [7:0]  vin_level,
  input  wire logic [7:0]  high_line_threshold,
  input  wire logic        line_undervoltage_flag,
  input  wire logic        vin_below_limit,
  // Status and control outputs
  output logic             line_period_valid,
  output logic             high_line_sel,
  output logic      [7:0]  current_gain,
  output logic      [7:0]  current_zero,
  output logic             input_voltage_low_flag,
  output logic             inrush_active,
  output logic             soft_start_active,
  output logic             startup_done
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] lower_q, upper_q, lo_gain_q, lo_zero_q, hi_gain_q, hi_zero_q, ramp_q, surge_q;

  // Register writes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lower_q   <= pfc_pkg::PFC_RESET_VALUE;
      upper_q   <= pfc_pkg::PFC_RESET_VALUE;
      lo_gain_q <= pfc_pkg::PFC_RESET_VALUE;
      lo_zero_q <= pfc_pkg::PFC_RESET_VALUE;
      hi_gain_q <= pfc_pkg::PFC_RESET_VALUE;
      hi_zero_q <= pfc_pkg::PFC_RESET_VALUE;
      ramp_q    <= pfc_pkg::PFC_RESET_VALUE;
      surge_q   <= pfc_pkg::PFC_RESET_VALUE;
    end else if (reg_wr) begin
      if (reg_addr == pfc_pkg::PFC_ADDR_LINE_PERIOD_LOWER) begin
        lower_q <= reg_wdata;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_LINE_PERIOD_UPPER) begin
        upper_q <= reg_wdata;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_LOW_LINE_GAIN) begin
        lo_gain_q <= reg_wdata;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_LOW_LINE_ZERO) begin
        lo_zero_q <= reg_wdata;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_HIGH_LINE_GAIN) begin
        hi_gain_q <= reg_wdata;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_HIGH_LINE_ZERO) begin
        hi_zero_q <= reg_wdata;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_RAMP_TIMING) begin
        ramp_q <= reg_wdata & pfc_pkg::PFC_RAMP_MASK;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_SURGE_TIMING) begin
        surge_q <= reg_wdata & pfc_pkg::PFC_SURGE_MASK;
      end
    end
  end

  // Register reads, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == pfc_pkg::PFC_ADDR_LINE_PERIOD_LOWER) begin
        reg_rdata <= lower_q;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_LINE_PERIOD_UPPER) begin
        reg_rdata <= upper_q;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_LOW_LINE_GAIN) begin
        reg_rdata <= lo_gain_q;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_LOW_LINE_ZERO) begin
        reg_rdata <= lo_zero_q;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_HIGH_LINE_GAIN) begin
        reg_rdata <= hi_gain_q;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_HIGH_LINE_ZERO) begin
        reg_rdata <= hi_zero_q;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_RAMP_TIMING) begin
        reg_rdata <= ramp_q & pfc_pkg::PFC_RAMP_MASK;
      end else if (reg_addr == pfc_pkg::PFC_ADDR_SURGE_TIMING) begin
        reg_rdata <= surge_q & pfc_pkg::PFC_SURGE_MASK;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Line window and coefficient selection
  // ----------------------------------------
  // Period inside the programmed window, both in 163.84 us steps
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      line_period_valid <= 1'b0;
    end else begin
      line_period_valid <= (line_period_meas >= lower_q) && (line_period_meas <= upper_q);
    end
  end

  // Gain and zero pair for the present line range
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      high_line_sel <= 1'b0;
      current_gain  <= 8'h00;
      current_zero  <= 8'h00;
    end else if (vin_level > high_line_threshold) begin
      high_line_sel <= 1'b1;
      current_gain  <= hi_gain_q;
      current_zero  <= hi_zero_q;
    end else begin
      high_line_sel <= 1'b0;
      current_gain  <= lo_gain_q;
      current_zero  <= lo_zero_q;
    end
  end

  // ----------------------------------------
  // Millisecond enable
  // ----------------------------------------
  logic [23:0] ms_div_q;
  logic        ms_tick;

  // Divider of clk_sys down to 1 ms
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ms_div_q <= 24'h000000;
    end else if (ms_tick) begin
      ms_div_q <= 24'h000000;
    end else begin
      ms_div_q <= ms_div_q + 24'h000001;
    end
  end
  assign ms_tick = (ms_div_q == 24'(MS_CYCLES - 1));

  // ----------------------------------------
  // Input-low measurement timer
  // ----------------------------------------
  logic [9:0] vlow_cnt_q;
  logic [1:0] vlow_sel;
  logic       vlow_step;
  logic [9:0] vlow_goal;

  // Step source and length per selection
  assign vlow_sel = surge_q[pfc_pkg::PFC_VLOW_SEL_LSB +: 2];
  always_comb begin
    vlow_step = line_quarter_tick;
    vlow_goal = 10'h001;
    case (vlow_sel)
      2'h0: begin vlow_step = line_quarter_tick; vlow_goal = 10'h001; end
      2'h1: begin vlow_step = line_quarter_tick; vlow_goal = 10'h002; end
      2'h2: begin vlow_step = ms_tick; vlow_goal = pfc_pkg::PFC_VLOW_2MS; end
      default: begin vlow_step = ms_tick; vlow_goal = pfc_pkg::PFC_VLOW_4MS; end
    endcase
  end

  // Flag once the input has stayed low for the whole interval
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      vlow_cnt_q             <= 10'h000;
      input_voltage_low_flag <= 1'b0;
    end else if (!vin_below_limit) begin
      vlow_cnt_q             <= 10'h000;
      input_voltage_low_flag <= 1'b0;
    end else if (vlow_cnt_q >= vlow_goal) begin
      input_voltage_low_flag <= 1'b1;
    end else if (vlow_step) begin
      vlow_cnt_q <= vlow_cnt_q + 10'h001;
    end
  end

  // ----------------------------------------
  // Start-up sequence
  // ----------------------------------------
  pfc_dly_if dly ();
  pfc_pkg::pfc_state_t state_q;
  logic [9:0] ramp_ms_q;
  logic       uv_prev_q;

  pfc_cycle_delay u_delay (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .dly     (dly)
  );

  // Delay requests on leaving undervoltage and on inrush
  assign dly.tick   = line_cycle_tick;
  assign dly.start  = (state_q == pfc_pkg::PFC_ST_OFF && !line_undervoltage_flag) ||
                      (state_q == pfc_pkg::PFC_ST_SURGE_WAIT && dly.done && !line_undervoltage_flag);
  assign dly.cycles = (state_q == pfc_pkg::PFC_ST_OFF) ? surge_q[2:0] :
                      ramp_q[pfc_pkg::PFC_SS_DELAY_LSB +: 3];

  // Sequencer, back to off whenever undervoltage returns
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= pfc_pkg::PFC_ST_OFF;
      ramp_ms_q <= 10'h000;
    end else if (line_undervoltage_flag) begin
      state_q   <= pfc_pkg::PFC_ST_OFF;
      ramp_ms_q <= 10'h000;
    end else begin
      case (state_q)
        pfc_pkg::PFC_ST_OFF: begin
          state_q <= pfc_pkg::PFC_ST_SURGE_WAIT;
        end
        pfc_pkg::PFC_ST_SURGE_WAIT: begin
          if (dly.done) begin
            state_q <= pfc_pkg::PFC_ST_RAMP_WAIT;
          end
        end
        pfc_pkg::PFC_ST_RAMP_WAIT: begin
          if (dly.done) begin
            state_q   <= pfc_pkg::PFC_ST_RAMP;
            ramp_ms_q <= 10'h000;
          end
        end
        pfc_pkg::PFC_ST_RAMP: begin
          if (ramp_ms_q >= pfc_pkg::PFC_RAMP_MS[ramp_q[2:0]]) begin
            state_q <= pfc_pkg::PFC_ST_RUN;
          end else if (ms_tick) begin
            ramp_ms_q <= ramp_ms_q + 10'h001;
          end
        end
        default: begin
          state_q <= pfc_pkg::PFC_ST_RUN;
        end
      endcase
    end
  end

  // Undervoltage edge history
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      uv_prev_q <= 1'b1;
    end else begin
      uv_prev_q <= line_undervoltage_flag;
    end
  end

  // Sequence outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      inrush_active     <= 1'b0;
      soft_start_active <= 1'b0;
      startup_done      <= 1'b0;
    end else begin
      inrush_active     <= !line_undervoltage_flag && !uv_prev_q && state_q != pfc_pkg::PFC_ST_OFF &&
                           !(state_q == pfc_pkg::PFC_ST_SURGE_WAIT && !dly.done);
      soft_start_active <= !line_undervoltage_flag && state_q == pfc_pkg::PFC_ST_RAMP &&
                           ramp_ms_q < pfc_pkg::PFC_RAMP_MS[ramp_q[2:0]];
      startup_done      <= !line_undervoltage_flag && state_q == pfc_pkg::PFC_ST_RUN;
    end
  end
endmodule // pfc_startup_line_config

// *** pfc_startup_line_config_assertions.sv ***
// Concurrent checks on the ports of the start-up and line configuration block.
// Assumes the bind at the foot attaches it to every instance of the top module.
`timescale 1ns/1ns
module pfc_slc_assertions #(
  parameter int MS_CYCLES = 10
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        arst_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  // Line measurements
  input wire logic        line_cycle_tick,
  input wire logic        line_quarter_tick,
  input wire logic        line_undervoltage_flag,
  input wire logic        vin_below_limit,
  input wire logic [7:0]  line_period_meas,
  input wire logic [7:0]  vin_level,
  input wire logic [7:0]  high_line_threshold,
  // Status and control
  input wire logic        line_period_valid,
  input wire logic        high_line_sel,
  input wire logic        input_voltage_low_flag,
  input wire logic        inrush_active,
  input wire logic        soft_start_active,
  input wire logic        startup_done,
  input wire logic [7:0]  current_gain,
  input wire logic [7:0]  current_zero
);
  logic        live_q;
  logic        mapped;
  int unsigned ramp_cnt_q;

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // Address falls inside the mapped block
  assign mapped = reg_addr >= pfc_pkg::PFC_ADDR_LINE_PERIOD_LOWER && reg_addr <= pfc_pkg::PFC_ADDR_SURGE_TIMING;

  // Goes high one edge after reset release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      live_q <= 1'b0;
    else
      live_q <= 1'b1;
  end

  // Length of the current soft-start ramp
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      ramp_cnt_q <= 0;
    else
      ramp_cnt_q <= soft_start_active ? ramp_cnt_q + 1 : 0;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_uv_quiet;
    !inrush_active [*2];
  endsequence

  chk_rdata_hold: assert property (live_q && !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ramp_rsvd: assert property (reg_rd && reg_addr == pfc_pkg::PFC_ADDR_RAMP_TIMING
    |=> reg_rdata[7:6] == 2'b00)
    else $error("ramp reserved bits not zero");
  chk_surge_rsvd: assert property (reg_rd && reg_addr == pfc_pkg::PFC_ADDR_SURGE_TIMING
    |=> reg_rdata[7:5] == 3'b000)
    else $error("surge reserved bits not zero");
  chk_line_pick: assert property (live_q |=> high_line_sel == $past(vin_level > high_line_threshold))
    else $error("high line select wrong");
  chk_uv_drop: assert property (line_undervoltage_flag |=> !inrush_active && !soft_start_active && !startup_done)
    else $error("start-up outputs held in undervoltage");
  chk_early_inrush: assert property ($fell(line_undervoltage_flag) |-> s_uv_quiet)
    else $error("inrush too soon");
  chk_ramp_inrush: assert property (soft_start_active |-> inrush_active)
    else $error("soft start without inrush");
  // Ramp ends, sequencer enters run, then done is registered: two edges
  chk_done_ramp: assert property ($rose(startup_done) |-> $past(soft_start_active, 2))
    else $error("done without ramp");
  chk_ramp_bound: assert property (ramp_cnt_q <= 729 * MS_CYCLES)
    else $error("soft start ran too long");
  chk_vlow_drop: assert property (live_q && !vin_below_limit |=> !input_voltage_low_flag)
    else $error("input low flag held");
  chk_vlow_cause: assert property ($rose(input_voltage_low_flag)
    |-> $past(vin_below_limit) && $past(vin_below_limit, 2))
    else $error("input low flag without cause");
endmodule // pfc_slc_assertions

bind pfc_startup_line_config pfc_slc_assertions #(.MS_CYCLES(MS_CYCLES)) pfc_slc_assertions_inst (.clk_sys, .arst_n,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .line_cycle_tick, .line_quarter_tick, .line_undervoltage_flag,
  .vin_below_limit, .line_period_meas, .vin_level, .high_line_threshold, .line_period_valid, .high_line_sel,
  .input_voltage_low_flag, .inrush_active, .soft_start_active, .startup_done, .current_gain, .current_zero);

// *** pfc_line_model.sv ***
// Model of the ac line: quarter-cycle and full-cycle tick pulses.
// Assumes ticks last one clock and change on falling edges.
`timescale 1ns/1ns
module pfc_line_model #(
  parameter int QP = 5
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Line ticks
  output logic      line_quarter_tick,
  output logic      line_cycle_tick
);
  int cnt;

  // Phase counter, full cycle every fourth quarter
  always @(negedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      line_quarter_tick <= 1'b0;
      line_cycle_tick <= 1'b0;
    end else begin
      cnt <= (cnt == 4 * QP - 1) ? 0 : cnt + 1;
      line_quarter_tick <= (cnt % QP == QP - 1);
      line_cycle_tick <= (cnt == 4 * QP - 1);
    end
  end
endmodule // pfc_line_model

// *** tb_top.sv ***
// Self-checking bench for the start-up and line configuration block.
// Assumes pfc_pkg, pfc_dly_if and the design modules compile first.
`timescale 1ns/1ns
module tb_top;
  localparam int MSC = 10;
  localparam int QP  = 5;
  logic        clk_sys, arst_n, reg_wr, reg_rd, line_cycle_tick, line_quarter_tick, line_undervoltage_flag;
  logic        vin_below_limit, line_period_valid, high_line_sel, input_voltage_low_flag;
  logic        inrush_active, soft_start_active, startup_done, hi;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, line_period_meas, vin_level, high_line_threshold, current_gain, current_zero;
  logic [31:0] seed;
  logic [7:0]  exp_q[$];
  logic [7:0]  shadow[8];
  logic [7:0]  vl[4] = '{8'h7f, 8'h80, 8'h81, 8'hff};
  logic [7:0]  pm[4] = '{8'h3f, 8'h40, 8'h60, 8'h61};
  int          failures = 0;
  int          cmp_count = 0;
  int          tick_cnt = 0;
  int          t, k, e;
  logic [3:0]  lv;

  // Watched levels, picked by index in wait_hi
  assign lv = {startup_done, soft_start_active, inrush_active, input_voltage_low_flag};

  pfc_startup_line_config #(.MS_CYCLES(MSC)) pfc_startup_line_config_inst (.clk_sys, .arst_n, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .line_cycle_tick, .line_quarter_tick, .line_period_meas, .vin_level,
    .high_line_threshold, .line_undervoltage_flag, .vin_below_limit, .line_period_valid, .high_line_sel,
    .current_gain, .current_zero, .input_voltage_low_flag, .inrush_active, .soft_start_active, .startup_done);
  pfc_line_model #(.QP(QP)) pfc_line_model_inst (.clk_sys, .arst_n, .line_quarter_tick, .line_cycle_tick);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] want);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(want);
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask

  task automatic wait_hi(input int w, output int n);
    n = 0;
    while (lv[w] !== 1'b1 && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 9000) failures++;
  endtask

  // One start-up run: surge count, ramp delay count, ramp code
  task automatic startup(input logic [2:0] nc, input logic [2:0] mc, input logic [2:0] rc);
    wr(pfc_pkg::PFC_ADDR_SURGE_TIMING, {5'h00, nc});
    wr(pfc_pkg::PFC_ADDR_RAMP_TIMING, {2'b00, mc, rc});
    @(posedge line_cycle_tick);
    @(negedge clk_sys);
    line_undervoltage_flag = 1'b0;
    k = tick_cnt;
    wait_hi(1, t);
    check(32'(tick_cnt - k), 32'(nc));
    k = tick_cnt;
    wait_hi(2, t);
    check(32'(tick_cnt - k), 32'(mc));
    wait_hi(3, t);
    e = int'(pfc_pkg::PFC_RAMP_MS[rc]) * MSC;
    check(32'(t + MSC + 3 >= e && t <= e + MSC + 3), 32'h1);
    @(negedge clk_sys);
    line_undervoltage_flag = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(32'({inrush_active, soft_start_active, startup_done}), 32'h0);
  endtask

  // ----------------------------------------
  // Clock, tick count, read monitor, watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) if (line_cycle_tick === 1'b1) tick_cnt++;

  // Read data compared with the oldest expected note
  always @(posedge clk_sys) if (reg_rd === 1'b1) begin
    @(negedge clk_sys);
    check(32'(reg_rdata), 32'(exp_q.pop_front()));
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    failures++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, vin_below_limit} = '0;
    {line_period_meas, vin_level, high_line_threshold} = 24'h000080;
    line_undervoltage_flag = 1'b1;
    seed = 32'ha5a055ef;
    arst_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    arst_n = 1'b1;
    // Reset values, random fill, masked readback, unmapped places
    for (int a = 0; a < 8; a++) rd(16'hfe27 + 16'(a), 8'h00);
    for (int a = 0; a < 8; a++) begin
      seed = lfsr(seed);
      shadow[a] = seed[7:0];
      wr(16'hfe27 + 16'(a), seed[7:0]);
    end
    wr(16'hfe2f, 8'hff);
    for (int a = 0; a < 8; a++) rd(16'hfe27 + 16'(a), shadow[a] & (a == 6 ? 8'h3f : a == 7 ? 8'h1f : 8'hff));
    rd(16'hfe2f, 8'h00);
    rd(16'hfe26, 8'h00);
    // Coefficient pick and period window at boundaries
    wr(pfc_pkg::PFC_ADDR_LINE_PERIOD_LOWER, 8'h40);
    wr(pfc_pkg::PFC_ADDR_LINE_PERIOD_UPPER, 8'h60);
    foreach (vl[i]) begin
      @(negedge clk_sys);
      vin_level = vl[i];
      line_period_meas = pm[i];
      repeat (2) @(negedge clk_sys);
      hi = vl[i] > 8'h80;
      check(32'(high_line_sel), 32'(hi));
      check(32'(current_gain), 32'(hi ? shadow[4] : shadow[2]));
      check(32'(current_zero), 32'(hi ? shadow[5] : shadow[3]));
      check(32'(line_period_valid), 32'(pm[i] >= 8'h40 && pm[i] <= 8'h60));
    end
    // Input-low timer for every selection
    for (int c = 0; c < 4; c++) begin
      wr(pfc_pkg::PFC_ADDR_SURGE_TIMING, {3'b000, 2'(c), 3'b000});
      @(negedge clk_sys);
      vin_below_limit = 1'b1;
      wait_hi(0, t);
      k = (c < 2) ? QP : MSC;
      e = (c == 0) ? 1 : (c == 3) ? 4 : 2;
      check(32'(t > (e - 1) * k && t <= e * k + 3), 32'h1);
      @(negedge clk_sys);
      vin_below_limit = 1'b0;
      repeat (2) @(negedge clk_sys);
    end
    // Start-up chain over every ramp code and both count extremes
    for (int i = 0; i < 8; i++) startup(3'(i), 3'(7 - i), 3'(i));
    close_out();
  end
endmodule // tb_top
